// ===== core/count_pair.sv
`timescale 1ns/1ps
`include "pwm_sync_defines.svh"

module count_pair #(
  parameter int WIDTH = 16
) (
  // Clock and reset
  input  wire logic             clock,
  input  wire logic             rstn,
  // Byte writes
  input  wire logic             write_low,
  input  wire logic             write_high,
  input  wire logic [7:0]       write_data,
  // Transfer
  input  wire logic             load,
  output logic      [WIDTH-1:0] held_value,
  output logic      [WIDTH-1:0] live_value
);

  typedef struct packed {
    logic [WIDTH-1:0] held;
    logic [WIDTH-1:0] live;
  } pair_t;

  pair_t pair_reg;
  pair_t pair_next;

  // Transfer takes the old buffer, so a write in the load cycle waits
  always_comb begin
    pair_next = pair_reg;
    if (load) begin
      pair_next.live = pair_reg.held;
    end
    if (write_low) begin
      pair_next.held[7:0] = write_data;
    end
    if (write_high) begin
      pair_next.held[WIDTH-1:8] = write_data[WIDTH-9:0];
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      pair_reg <= '{held: WIDTH'(`COUNT_RESET),
                    live: WIDTH'(`COUNT_RESET)};
    end else begin
      pair_reg <= pair_next;
    end
  end

  assign held_value = pair_reg.held;
  assign live_value = pair_reg.live;

endmodule // count_pair

// ===== core/peer_select.sv
`timescale 1ns/1ps

module peer_select (
  // Selection
  input  wire logic [1:0] select,
  input  wire logic [2:0] events,
  // Result
  output logic            chosen
);

  // The fourth code picks nothing, so a reserved setting stays inert
  always_comb begin
    case (select)
      2'b00:   chosen = events[0];
      2'b01:   chosen = events[1];
      2'b10:   chosen = events[2];
      default: chosen = 1'b0;
    endcase
  end

endmodule // peer_select

// ===== core/pwm_reload_offset_sync.sv
// Implementation choices: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ps
`include "pwm_sync_defines.svh"

module pwm_reload_offset_sync (
  // Clock and reset
  input  wire logic                    clock,
  input  wire logic                    rstn,
  // Register port
  input  wire logic [3:0]              addr,
  input  wire logic [7:0]              wdata,
  input  wire logic                    wr,
  input  wire logic                    rd,
  output logic      [7:0]              rdata,
  // Timer state
  input  wire logic [15:0]             pwm_timer_count,
  input  wire logic                    timer_counting_up,
  input  wire pwm_sync_pkg::wave_mode_t waveform_mode,
  // Peer events
  input  wire logic                    load_event_first_peer,
  input  wire logic                    load_event_second_peer,
  input  wire logic                    load_event_third_peer,
  input  wire logic                    offset_event_first_peer,
  input  wire logic                    offset_event_second_peer,
  input  wire logic                    offset_event_third_peer,
  // Events to peers and timer
  output logic                         load_event,
  output logic                         offset_match_output,
  output logic                         timer_reset,
  output logic                         sync_start,
  output logic                         run_enable,
  // Live values
  output logic                         buffered_output_control_bit,
  output logic      [15:0]             phase_count,
  output logic      [15:0]             duty_count,
  output logic      [15:0]             period_count,
  output logic      [15:0]             offset_count
);
  import pwm_sync_pkg::*;

  typedef struct packed {
    logic         load_armed;
    logic         load_on_trigger;
    logic [1:0]   load_trigger_select;
    offset_mode_t offset_mode_select;
    logic         offset_match_direction;
    logic [1:0]   offset_source_select;
    logic         out_ctrl_held;
    logic         out_ctrl_live;
    logic         trigger_seen;
    sync_state_t  sync_state;
    logic         load_pulse;
    logic         reset_pulse;
    logic         start_pulse;
    logic         offset_hit;
    logic [7:0]   rdata;
  } state_t;

  state_t s_reg;
  state_t s_next;

  logic [15:0] held_vals [4];
  logic [15:0] live_vals [4];
  logic        trig_ev;
  logic        offset_ev;
  logic        period_hit;
  logic        do_load;
  logic        wr_reload;
  logic        wr_offset;

  // ****************************************
  // Peer selection
  // ****************************************
  // The reserved code 11 selects nothing, so a bad setting cannot self-trigger
  peer_select load_sel_u (
    .select (s_reg.load_trigger_select),
    .events ({load_event_third_peer, load_event_second_peer,
              load_event_first_peer}),
    .chosen (trig_ev)
  );

  peer_select offset_sel_u (
    .select (s_reg.offset_source_select),
    .events ({offset_event_third_peer, offset_event_second_peer,
              offset_event_first_peer}),
    .chosen (offset_ev)
  );

  // ****************************************
  // Count buffers
  // ****************************************
  // Index 0 phase, 1 duty, 2 period, 3 offset
  for (genvar i = 0; i < 4; i++) begin : g_pair
    count_pair #(
      .WIDTH (16)
    ) pair_u (
      .clock      (clock),
      .rstn       (rstn),
      .write_low  (wr && addr == 4'(`ADDR_PHASE_LOW + 2 * i)),
      .write_high (wr && addr == 4'(`ADDR_PHASE_HIGH + 2 * i)),
      .write_data (wdata),
      .load       (do_load),
      .held_value (held_vals[i]),
      .live_value (live_vals[i])
    );
  end

  assign period_hit = pwm_timer_count == live_vals[2];
  assign wr_reload  = wr && addr == `ADDR_RELOAD_CTRL;
  assign wr_offset  = wr && addr == `ADDR_OFFSET_CTRL;
  // Registered armed state is used, so arming in a match cycle waits
  assign do_load    = period_hit && s_reg.load_armed &&
                      (!s_reg.load_on_trigger || s_reg.trigger_seen);

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    s_next = s_reg;
    s_next.load_pulse  = 1'b0;
    s_next.reset_pulse = 1'b0;
    s_next.start_pulse = 1'b0;
    s_next.rdata       = 8'h00;

    // A trigger coinciding with the period match loads one period later
    if (s_reg.load_armed && s_reg.load_on_trigger && trig_ev) begin
      s_next.trigger_seen = 1'b1;
    end
    if (do_load) begin
      s_next.load_armed    = 1'b0;
      s_next.trigger_seen  = 1'b0;
      s_next.out_ctrl_live = s_reg.out_ctrl_held;
      s_next.load_pulse    = 1'b1;
    end

    case (s_reg.offset_mode_select)
      OFFSET_INDEPENDENT: begin
        s_next.sync_state = SYNC_RUN;
      end
      OFFSET_SLAVE_RUN: begin
        if (s_reg.sync_state == SYNC_WAIT && offset_ev) begin
          s_next.sync_state  = SYNC_RUN;
          s_next.start_pulse = 1'b1;
        end
      end
      OFFSET_ONE_SHOT: begin
        if (s_reg.sync_state == SYNC_WAIT && offset_ev) begin
          s_next.sync_state  = SYNC_RUN;
          s_next.start_pulse = 1'b1;
        end else if (s_reg.sync_state == SYNC_RUN && period_hit) begin
          s_next.sync_state = SYNC_DONE;
        end
      end
      OFFSET_CONTINUOUS: begin
        s_next.sync_state = SYNC_RUN;
        if (offset_ev) begin
          s_next.reset_pulse = 1'b1;
          s_next.start_pulse = 1'b1;
        end
      end
      default: begin
        s_next.sync_state = SYNC_WAIT;
      end
    endcase

    // Direction only qualifies the match in center aligned mode
    s_next.offset_hit = pwm_timer_count == live_vals[3] &&
                        (waveform_mode != WAVE_CENTER ||
                         timer_counting_up ==
                         s_reg.offset_match_direction);

    // Software writes come last so that a new arming wins over the clear
    if (wr_reload) begin
      s_next.load_armed          = wdata[`LOAD_ARMED_BIT];
      s_next.load_on_trigger     = wdata[`LOAD_ON_TRIG_BIT];
      s_next.load_trigger_select = wdata[`LOAD_SEL_LSB +: 2];
      if (!wdata[`LOAD_ARMED_BIT]) begin
        s_next.trigger_seen = 1'b0;
      end
    end
    if (wr_offset) begin
      s_next.offset_mode_select =
        offset_mode_t'(wdata[`OFFSET_MODE_LSB +: 2]);
      s_next.offset_match_direction = wdata[`OFFSET_DIR_BIT];
      s_next.offset_source_select   = wdata[`OFFSET_SRC_LSB +: 2];
      s_next.sync_state             = SYNC_WAIT;
    end
    if (wr && addr == `ADDR_OUTPUT_CTRL) begin
      s_next.out_ctrl_held = wdata[`OUT_CTRL_BIT];
    end

    // ****************************************
    // Read mux
    // ****************************************
    if (rd) begin
      case (addr)
        `ADDR_RELOAD_CTRL: s_next.rdata = {s_reg.load_armed,
          s_reg.load_on_trigger, 4'h0, s_reg.load_trigger_select};
        `ADDR_OFFSET_CTRL: s_next.rdata = {1'b0,
          s_reg.offset_mode_select, s_reg.offset_match_direction,
          2'h0, s_reg.offset_source_select};
        `ADDR_PHASE_LOW:   s_next.rdata = held_vals[0][7:0];
        `ADDR_PHASE_HIGH:  s_next.rdata = held_vals[0][15:8];
        `ADDR_DUTY_LOW:    s_next.rdata = held_vals[1][7:0];
        `ADDR_DUTY_HIGH:   s_next.rdata = held_vals[1][15:8];
        `ADDR_PERIOD_LOW:  s_next.rdata = held_vals[2][7:0];
        `ADDR_PERIOD_HIGH: s_next.rdata = held_vals[2][15:8];
        `ADDR_OFFSET_LOW:  s_next.rdata = held_vals[3][7:0];
        `ADDR_OFFSET_HIGH: s_next.rdata = held_vals[3][15:8];
        `ADDR_OUTPUT_CTRL: s_next.rdata = {6'h00, s_reg.out_ctrl_live,
          s_reg.out_ctrl_held};
        `ADDR_SYNC_STATUS: s_next.rdata = {5'h00, s_reg.trigger_seen,
          s_reg.sync_state};
        default:           s_next.rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      s_reg <= '{
        load_armed:             1'(`RELOAD_CTRL_RESET >> `LOAD_ARMED_BIT),
        load_on_trigger:        1'b0,
        load_trigger_select:    2'h0,
        offset_mode_select:     OFFSET_INDEPENDENT,
        offset_match_direction: 1'b0,
        offset_source_select:   2'h0,
        out_ctrl_held:          1'b0,
        out_ctrl_live:          1'b0,
        trigger_seen:           1'b0,
        sync_state:             SYNC_WAIT,
        load_pulse:             1'b0,
        reset_pulse:            1'b0,
        start_pulse:            1'b0,
        offset_hit:             1'b0,
        rdata:                  8'h00
      };
    end else begin
      s_reg <= s_next;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign rdata                       = s_reg.rdata;
  assign load_event                  = s_reg.load_pulse;
  assign offset_match_output         = s_reg.offset_hit;
  assign timer_reset                 = s_reg.reset_pulse;
  assign sync_start                  = s_reg.start_pulse;
  assign run_enable                  = s_reg.sync_state == SYNC_RUN;
  assign buffered_output_control_bit = s_reg.out_ctrl_live;
  assign phase_count                 = live_vals[0];
  assign duty_count                  = live_vals[1];
  assign period_count                = live_vals[2];
  assign offset_count                = live_vals[3];

  // ****************************************
  // Checks
  // ****************************************
  a_load_clears_armed: assert property (
    @(posedge clock) disable iff (!rstn)
    do_load && !(wr_reload && wdata[`LOAD_ARMED_BIT]) |=>
      !s_reg.load_armed && s_reg.load_pulse
  ) else $error("armed bit not cleared after reload");

  a_cancel_no_load: assert property (
    @(posedge clock) disable iff (!rstn)
    wr_reload && !wdata[`LOAD_ARMED_BIT] |-> ##2 !s_reg.load_pulse
  ) else $error("cancelled arming still loaded");

  a_immediate_load: assert property (
    @(posedge clock) disable iff (!rstn)
    s_reg.load_armed && !s_reg.load_on_trigger && period_hit |=>
      s_reg.load_pulse
  ) else $error("immediate reload missed period end");

  a_trigger_gate: assert property (
    @(posedge clock) disable iff (!rstn)
    s_reg.load_on_trigger && !s_reg.trigger_seen |=> !s_reg.load_pulse
  ) else $error("triggered reload without trigger");

  a_pairs_together: assert property (
    @(posedge clock) disable iff (!rstn)
    s_reg.load_pulse |-> phase_count == $past(held_vals[0]) &&
      duty_count == $past(held_vals[1]) &&
      period_count == $past(held_vals[2]) &&
      offset_count == $past(held_vals[3])
  ) else $error("count pairs not transferred together");

  a_live_stable: assert property (
    @(posedge clock) disable iff (!rstn)
    !s_reg.load_pulse |-> $stable(period_count) && $stable(duty_count)
  ) else $error("live count changed without a load");

  a_arm_collision: assert property (
    @(posedge clock) disable iff (!rstn)
    wr_reload && wdata[`LOAD_ARMED_BIT] && !s_reg.load_armed &&
      period_hit |=> !s_reg.load_pulse
  ) else $error("arming in match cycle loaded at once");

  a_independent_run: assert property (
    @(posedge clock) disable iff (!rstn)
    s_reg.offset_mode_select == OFFSET_INDEPENDENT && !wr_offset |=>
      !s_reg.start_pulse && !s_reg.reset_pulse && run_enable
  ) else $error("independent instance reacted to peer");

  a_continuous_reset: assert property (
    @(posedge clock) disable iff (!rstn)
    s_reg.offset_mode_select == OFFSET_CONTINUOUS && offset_ev &&
      !wr_offset |=> timer_reset && sync_start
  ) else $error("continuous slave missed timer reset");

  a_one_shot_end: assert property (
    @(posedge clock) disable iff (!rstn)
    s_reg.offset_mode_select == OFFSET_ONE_SHOT &&
      s_reg.sync_state == SYNC_RUN && period_hit && !wr_offset |=>
      !run_enable
  ) else $error("one-shot slave kept running");

  a_center_direction: assert property (
    @(posedge clock) disable iff (!rstn)
    s_reg.offset_hit && $past(waveform_mode) == WAVE_CENTER |->
      $past(timer_counting_up) == $past(s_reg.offset_match_direction)
  ) else $error("center match fired in wrong direction");

endmodule // pwm_reload_offset_sync

// ===== include/pwm_sync_defines.svh
`ifndef PWM_SYNC_DEFINES_SVH
`define PWM_SYNC_DEFINES_SVH

// ****************************************
// Register offsets
// ****************************************
`define ADDR_RELOAD_CTRL   4'h0
`define ADDR_OFFSET_CTRL   4'h1
`define ADDR_PHASE_LOW     4'h2
`define ADDR_PHASE_HIGH    4'h3
`define ADDR_DUTY_LOW      4'h4
`define ADDR_DUTY_HIGH     4'h5
`define ADDR_PERIOD_LOW    4'h6
`define ADDR_PERIOD_HIGH   4'h7
`define ADDR_OFFSET_LOW    4'h8
`define ADDR_OFFSET_HIGH   4'h9
`define ADDR_OUTPUT_CTRL   4'ha
`define ADDR_SYNC_STATUS   4'hb

// ****************************************
// Field positions
// ****************************************
`define LOAD_ARMED_BIT     7
`define LOAD_ON_TRIG_BIT   6
`define LOAD_SEL_LSB       0
`define OFFSET_MODE_LSB    5
`define OFFSET_DIR_BIT     4
`define OFFSET_SRC_LSB     0
`define OUT_CTRL_BIT       0

// ****************************************
// Reset values
// ****************************************
`define RELOAD_CTRL_RESET  8'h00
`define OFFSET_CTRL_RESET  8'h00
`define COUNT_RESET        16'h0000

`endif

// ===== include/pwm_sync_pkg.sv
package pwm_sync_pkg;

  typedef enum logic [1:0] {
    WAVE_STANDARD = 2'b00,
    WAVE_SET      = 2'b01,
    WAVE_TOGGLE   = 2'b10,
    WAVE_CENTER   = 2'b11
  } wave_mode_t;

  typedef enum logic [1:0] {
    OFFSET_INDEPENDENT = 2'b00,
    OFFSET_SLAVE_RUN   = 2'b01,
    OFFSET_ONE_SHOT    = 2'b10,
    OFFSET_CONTINUOUS  = 2'b11
  } offset_mode_t;

  typedef enum logic [1:0] {
    SYNC_WAIT = 2'b00,
    SYNC_RUN  = 2'b01,
    SYNC_DONE = 2'b10
  } sync_state_t;

endpackage

// ===== test/peer_model.sv
`timescale 1ns/1ps

module peer_model (
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        rstn,
  // Commands from the bench
  input  wire logic [15:0] period_limit,
  input  wire logic [2:0]  fire_load,
  input  wire logic [2:0]  fire_offset,
  // Toward the block
  output logic      [15:0] pwm_timer_count,
  output logic      [2:0]  load_events,
  output logic      [2:0]  offset_events
);
  // ****************************************
  // Peers and shared timer
  // ****************************************
  // Peer events are single-cycle pulses, never held levels
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      pwm_timer_count <= 16'h0000;
      load_events     <= 3'h0;
      offset_events   <= 3'h0;
    end else begin
      if (pwm_timer_count >= period_limit) begin
        pwm_timer_count <= 16'h0000;
      end else begin
        pwm_timer_count <= pwm_timer_count + 16'h0001;
      end
      load_events   <= fire_load;
      offset_events <= fire_offset;
    end
  end
endmodule // peer_model

// ===== test/test_pwm_reload_offset_sync.sv
`timescale 1ns/1ps
`include "pwm_sync_defines.svh"

module test_pwm_reload_offset_sync;
  import pwm_sync_pkg::*;
  // ****************************************
  // Signals
  // ****************************************
  localparam logic [15:0] LIM = 16'h0013;
  logic        clock  = 1'b0;
  logic        rstn   = 1'b0;
  logic [3:0]  addr   = 4'h0;
  logic [7:0]  wdata  = 8'h00;
  logic        wr     = 1'b0;
  logic        rd     = 1'b0;
  logic        rd_q   = 1'b0;
  logic        up     = 1'b1;
  wave_mode_t  wmode  = WAVE_STANDARD;
  logic [2:0]  fire_l = 3'h0;
  logic [2:0]  fire_o = 3'h0;
  logic [7:0]  rdata;
  logic [15:0] tmr;
  logic [2:0]  ld_ev;
  logic [2:0]  of_ev;
  logic        load_event;
  logic        of_match;
  logic        t_reset;
  logic        s_start;
  logic        run_en;
  logic        out_bit;
  logic [15:0] ph;
  logic [15:0] dc;
  logic [15:0] pr;
  logic [15:0] ofs;
  logic [7:0]  exp_q[$];
  logic [15:0] vals[4];
  logic [15:0] live[4];
  int          failures;
  int          n_checks;
  int          c_load;
  int          c_sync;
  int          c_rst;
  int          c_match;

  always #2.5 clock = ~clock;

  peer_model peer_u (
    .clock(clock), .rstn(rstn), .period_limit(LIM),
    .fire_load(fire_l), .fire_offset(fire_o),
    .pwm_timer_count(tmr), .load_events(ld_ev), .offset_events(of_ev)
  );

  pwm_reload_offset_sync dut_u (
    .clock(clock), .rstn(rstn), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .pwm_timer_count(tmr),
    .timer_counting_up(up), .waveform_mode(wmode),
    .load_event_first_peer(ld_ev[0]), .load_event_second_peer(ld_ev[1]),
    .load_event_third_peer(ld_ev[2]),
    .offset_event_first_peer(of_ev[0]),
    .offset_event_second_peer(of_ev[1]),
    .offset_event_third_peer(of_ev[2]),
    .load_event(load_event), .offset_match_output(of_match),
    .timer_reset(t_reset), .sync_start(s_start), .run_enable(run_en),
    .buffered_output_control_bit(out_bit), .phase_count(ph),
    .duty_count(dc), .period_count(pr), .offset_count(ofs)
  );

  // ****************************************
  // Checking and bus tasks
  // ****************************************
  task check(input string nm, input logic [15:0] seen, input logic [15:0] e);
    n_checks++;
    if (seen !== e) begin
      failures++;
      $display("wrong value %s expected %h seen %h", nm, e, seen);
    end
  endtask

  task results;
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  task wr_reg(input logic [3:0] a, input logic [7:0] d);
    @(posedge clock);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clock);
    wr <= 1'b0;
  endtask

  // The note goes on the queue; the watcher compares the data
  task rd_reg(input logic [3:0] a, input logic [7:0] e);
    @(posedge clock);
    addr <= a;
    rd   <= 1'b1;
    exp_q.push_back(e);
    @(posedge clock);
    rd <= 1'b0;
  endtask

  always @(posedge clock) rd_q <= rd;
  always @(negedge clock) begin
    if (rd_q) begin
      check("rdata", {8'h00, rdata}, {8'h00, exp_q.pop_front()});
    end
  end

  task fire(input logic [2:0] l, input logic [2:0] o);
    @(posedge clock);
    fire_l <= l;
    fire_o <= o;
    @(posedge clock);
    fire_l <= 3'h0;
    fire_o <= 3'h0;
  endtask

  task watch(input int n);
    c_load  = 0;
    c_sync  = 0;
    c_rst   = 0;
    c_match = 0;
    repeat (n) begin
      @(negedge clock);
      c_load  += int'(load_event === 1'b1);
      c_sync  += int'(s_start === 1'b1);
      c_rst   += int'(t_reset === 1'b1);
      c_match += int'(of_match === 1'b1);
    end
  endtask

  task wait_load;
    int i;
    for (i = 0; i < 200 && load_event !== 1'b1; i++) @(negedge clock);
    if (i == 200) begin
      failures++;
      results();
    end
  endtask

  // Arming early in a period keeps a period match out of the way
  task align;
    int i;
    for (i = 0; i < 64 && tmr !== 16'h0001; i++) @(negedge clock);
    if (i == 64) begin
      failures++;
      results();
    end
  endtask

  task check_live;
    check("phase", ph, live[0]);
    check("duty", dc, live[1]);
    check("period", pr, live[2]);
    check("offset", ofs, live[3]);
  endtask

  // Period stays at the timer limit so matches keep happening
  task load_bufs;
    int i;
    vals[0] = 16'($urandom);
    vals[1] = 16'($urandom);
    vals[2] = LIM;
    vals[3] = 16'($urandom_range(LIM - 1, 1));
    for (i = 0; i < 4; i++) begin
      wr_reg(4'(2 + 2 * i), vals[i][7:0]);
      wr_reg(4'(3 + 2 * i), vals[i][15:8]);
    end
    for (i = 0; i < 4; i++) begin
      rd_reg(4'(2 + 2 * i), vals[i][7:0]);
      rd_reg(4'(3 + 2 * i), vals[i][15:8]);
    end
    check_live;
  endtask

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    int s;
    int m;
    int w;
    int d;
    int u;
    void'($urandom(27359));
    live = '{16'h0000, 16'h0000, 16'h0000, 16'h0000};
    repeat (6) @(posedge clock);
    rstn <= 1'b1;
    rd_reg(`ADDR_RELOAD_CTRL, 8'h00);
    rd_reg(`ADDR_OFFSET_CTRL, 8'h00);
    rd_reg(4'hc, 8'h00);
    load_bufs;
    wr_reg(`ADDR_OUTPUT_CTRL, 8'h01);
    align;
    wr_reg(`ADDR_RELOAD_CTRL, 8'h80);
    wait_load;
    live = vals;
    check_live;
    check("out bit", {15'h0000, out_bit}, 16'h0001);
    rd_reg(`ADDR_OUTPUT_CTRL, 8'h03);
    rd_reg(`ADDR_RELOAD_CTRL, 8'h00);
    load_bufs;
    align;
    wr_reg(`ADDR_RELOAD_CTRL, 8'h80);
    wr_reg(`ADDR_RELOAD_CTRL, 8'h00);
    watch(3 * (LIM + 1));
    check("cancel", 16'(c_load), 16'h0000);
    check_live;
    // Own source never chosen: selects stay within 00..10
    for (s = 0; s < 3; s++) begin
      load_bufs;
      wr_reg(`ADDR_RELOAD_CTRL, 8'hc0 | 8'(s));
      fire(~(3'b001 << s), 3'h0);
      watch(2 * (LIM + 1));
      check("early load", 16'(c_load), 16'h0000);
      fire(3'b001 << s, 3'h0);
      wait_load;
      live = vals;
      check_live;
      rd_reg(`ADDR_RELOAD_CTRL, 8'h40 | 8'(s));
    end
    for (m = 0; m < 4; m++) for (s = 0; s < 3; s++) begin
      wr_reg(`ADDR_OFFSET_CTRL, 8'((m << 5) | s));
      fire(3'h0, ~(3'b001 << s));
      watch(4);
      check("stray sync", 16'(c_sync), 16'h0000);
      fire(3'h0, 3'b001 << s);
      watch(4);
      check("sync", 16'(c_sync), 16'(m != 0));
      check("treset", 16'(c_rst), 16'(m == 3));
      if (m == 1) check("run", {15'h0000, run_en}, 16'h0001);
      if (m == 1) rd_reg(`ADDR_SYNC_STATUS, 8'h01);
    end
    for (w = 0; w < 4; w++) for (d = 0; d < 2; d++) begin
      for (u = 0; u < 2; u++) begin
        @(posedge clock);
        wmode <= wave_mode_t'(w);
        up    <= 1'(u);
        wr_reg(`ADDR_OFFSET_CTRL, 8'(d << 4));
        @(posedge clock);
        watch(LIM + 2);
        check("match", 16'(c_match != 0), 16'(w != 3 || d == u));
      end
    end
    results();
  end
endmodule // test_pwm_reload_offset_sync
